// ==== core/run_clk_pkg.sv ====
package run_clk_pkg;
	localparam logic [3:0]  OFS_RUN_CFG     = 4'h0;
	localparam logic [3:0]  OFS_RUN_CFG_EXT = 4'h4;
	localparam logic [3:0]  OFS_MODE        = 4'h8;
	localparam logic [3:0]  OFS_STATUS      = 4'hc;
	localparam logic [31:0] RUN_CFG_RESET   = 32'h0780_3ad1;
	localparam logic [31:0] RUN_CFG_WMASK   = 32'h0fc0_2bf3;
	localparam logic [31:0] EXT_RESET       = 32'h0780_2810;
	localparam logic [31:0] EXT_WMASK       = 32'h9f80_2870;
	localparam int POS_AUTO_GATE = 27;
	localparam int POS_DIV_LSB  = 23;
	localparam int POS_USEDIV   = 22;
	localparam int POS_POWER_DOWN = 13;
	localparam int POS_BYPASS   = 11;
	localparam int POS_CRYSTAL_LSB = 6;
	localparam int POS_SRC_LSB  = 4;
	localparam int POS_EXT_SEL  = 31;
	localparam logic [5:0]  MIN_DIV_DEFAULT = 6'h03;
	localparam real         PLL_TARGET_MHZ  = 400.0;
	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_SLEEP = 2'b01,
		MODE_DEEP  = 2'b10
	} power_mode_t;
	typedef enum logic [1:0] {
		GATE_RUN   = 2'b00,
		GATE_SLEEP = 2'b01,
		GATE_DEEP  = 2'b10
	} gate_sel_t;
endpackage : run_clk_pkg

// ==== core/gate_select.sv ====
`timescale 1ns/1ps
module gate_select (
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	input  wire logic        i_auto_gating_select,
	input  wire logic [1:0]  i_mode,
	input  wire logic [31:0] i_run_gating_regs,
	input  wire logic [31:0] i_sleep_gating_regs,
	input  wire logic [31:0] i_deep_sleep_gating_regs,
	output logic      [1:0]  o_sel,
	output logic      [31:0] o_gate
);
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_sel  <= run_clk_pkg::GATE_RUN;
			o_gate <= 32'h0000_0000;
		end else if (!i_auto_gating_select ||
				i_mode == run_clk_pkg::MODE_RUN) begin
			o_sel  <= run_clk_pkg::GATE_RUN;
			o_gate <= i_run_gating_regs;
		end else if (i_mode == run_clk_pkg::MODE_DEEP) begin
			o_sel  <= run_clk_pkg::GATE_DEEP;
			o_gate <= i_deep_sleep_gating_regs;
		end else begin
			o_sel  <= run_clk_pkg::GATE_SLEEP;
			o_gate <= i_sleep_gating_regs;
		end
	end

	AST_RUN_ALWAYS: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		i_mode == run_clk_pkg::MODE_RUN |=> o_gate == $past(i_run_gating_regs))
		else $error("run mode did not use run gating set");
	AST_AUTO_OFF: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		!i_auto_gating_select |=> o_sel == run_clk_pkg::GATE_RUN)
		else $error("auto gating off but non-run set chosen");
	AST_AUTO_DEEP: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		i_auto_gating_select && i_mode == run_clk_pkg::MODE_DEEP
		|=> o_gate == $past(i_deep_sleep_gating_regs))
		else $error("deep sleep gating set not used");
endmodule : gate_select

// ==== core/run_clock_cfg.sv ====
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module run_clock_cfg (
	input  wire logic        i_sys_clk,
	input  wire logic        i_srst,
	input  wire logic [3:0]  i_address,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	input  wire logic [3:0]  i_byteenable,
	output logic      [31:0] o_readdata,
	output logic             o_waitrequest,
	input  wire logic [5:0]  i_min_divisor_limit,
	input  wire logic [31:0] i_run_gating_regs,
	input  wire logic [31:0] i_sleep_gating_regs,
	input  wire logic [31:0] i_deep_sleep_gating_regs,
	output logic      [31:0] o_periph_gate,
	output logic      [1:0]  o_gate_sel,
	output logic             o_pll_power_down,
	output logic             o_clk_from_pll,
	output logic             o_clk_through_div,
	output logic      [5:0]  o_eff_divisor,
	output logic      [1:0]  o_osc_source,
	output logic      [3:0]  o_crystal_select
);
	logic [31:0] run_clock_config;
	logic [31:0] run_clock_config_ext;
	logic [1:0]  mode;
	logic        ack;
	logic [31:0] next_run;
	logic [31:0] next_ext;
	logic [31:0] bmask;
	logic        ext_sel;
	logic        bypass;
	logic [5:0]  raw_div;
	logic [5:0]  next_div;

	// one wait cycle: answer lands with ack registered
	assign o_waitrequest = (i_read || i_write) && !ack;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst)
			ack <= 1'b0;
		else
			ack <= (i_read || i_write) && !ack;
	end

	always_comb begin
		bmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
			{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
		next_run = (run_clock_config & ~(bmask & run_clk_pkg::RUN_CFG_WMASK))
			| (i_writedata & bmask & run_clk_pkg::RUN_CFG_WMASK);
		next_ext = (run_clock_config_ext & ~(bmask & run_clk_pkg::EXT_WMASK))
			| (i_writedata & bmask & run_clk_pkg::EXT_WMASK);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst)
			run_clock_config <= run_clk_pkg::RUN_CFG_RESET;
		else if (i_write && ack && i_address == run_clk_pkg::OFS_RUN_CFG)
			run_clock_config <= next_run;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst)
			run_clock_config_ext <= run_clk_pkg::EXT_RESET;
		else if (i_write && ack && i_address == run_clk_pkg::OFS_RUN_CFG_EXT)
			run_clock_config_ext <= next_ext;
	end

	// power mode is a register here; real chips take it from the core
	always_ff @(posedge i_sys_clk) begin
		if (i_srst)
			mode <= run_clk_pkg::MODE_RUN;
		else if (i_write && ack && i_address == run_clk_pkg::OFS_MODE
				&& i_byteenable[0])
			mode <= (i_writedata[1:0] == 2'b11) ? run_clk_pkg::MODE_RUN
				: i_writedata[1:0];
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst)
			o_readdata <= 32'h0000_0000;
		else if (i_read && !ack) begin
			case (i_address)
			run_clk_pkg::OFS_RUN_CFG:     o_readdata <= run_clock_config;
			run_clk_pkg::OFS_RUN_CFG_EXT: o_readdata <= run_clock_config_ext;
			run_clk_pkg::OFS_MODE:        o_readdata <= {30'h0, mode};
			// bit 4 kept zero so the crystal code sits in the low nibble
			run_clk_pkg::OFS_STATUS:      o_readdata <= {16'h0, o_gate_sel,
				o_eff_divisor, o_clk_through_div, o_clk_from_pll,
				o_pll_power_down, 1'b0, o_crystal_select};
			default:                      o_readdata <= 32'h0000_0000;
			endcase
		end
	end

	always_comb begin
		ext_sel = run_clock_config_ext[run_clk_pkg::POS_EXT_SEL];
		bypass  = ext_sel ? run_clock_config_ext[run_clk_pkg::POS_BYPASS]
			: run_clock_config[run_clk_pkg::POS_BYPASS];
		raw_div = ext_sel ? run_clock_config_ext[run_clk_pkg::POS_DIV_LSB +: 6]
			: {2'b00, run_clock_config[run_clk_pkg::POS_DIV_LSB +: 4]};
		// pll drives the clock only when not bypassed
		if (!bypass && raw_div < i_min_divisor_limit)
			next_div = i_min_divisor_limit;
		else
			next_div = raw_div;
	end

	// the pll setting lookup (nominal 400 MHz) lives in the analog macro;
	// this block only hands it the crystal code
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_pll_power_down  <= 1'b1;
			o_clk_from_pll    <= 1'b0;
			o_clk_through_div <= 1'b0;
			o_eff_divisor     <= 6'h0f;
			o_osc_source      <= 2'h1;
			o_crystal_select  <= 4'hb;
		end else begin
			o_pll_power_down  <= ext_sel
				? run_clock_config_ext[run_clk_pkg::POS_POWER_DOWN]
				: run_clock_config[run_clk_pkg::POS_POWER_DOWN];
			o_clk_from_pll    <= !bypass;
			o_clk_through_div <= !bypass ||
				run_clock_config[run_clk_pkg::POS_USEDIV];
			o_eff_divisor     <= next_div;
			o_osc_source      <= ext_sel
				? run_clock_config_ext[run_clk_pkg::POS_SRC_LSB +: 2]
				: run_clock_config[run_clk_pkg::POS_SRC_LSB +: 2];
			o_crystal_select  <= run_clock_config[run_clk_pkg::POS_CRYSTAL_LSB +: 4];
		end
	end

	gate_select u_gate (
		.i_sys_clk                (i_sys_clk),
		.i_srst                   (i_srst),
		.i_auto_gating_select     (run_clock_config[run_clk_pkg::POS_AUTO_GATE]),
		.i_mode                   (mode),
		.i_run_gating_regs        (i_run_gating_regs),
		.i_sleep_gating_regs      (i_sleep_gating_regs),
		.i_deep_sleep_gating_regs (i_deep_sleep_gating_regs),
		.o_sel                    (o_gate_sel),
		.o_gate                   (o_periph_gate)
	);

	AST_PLL_FORCES_DIV: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		o_clk_from_pll |-> o_clk_through_div)
		else $error("pll clock not routed through divider");
	AST_MIN_CLAMP: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		!bypass && raw_div < i_min_divisor_limit
		|=> o_eff_divisor == $past(i_min_divisor_limit))
		else $error("divisor not clamped with pll");
	AST_NO_CLAMP: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		bypass |=> o_eff_divisor == $past(raw_div))
		else $error("divisor clamped without pll");
	AST_POWER_DOWN: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		!ext_sel |=> o_pll_power_down
			== $past(run_clock_config[run_clk_pkg::POS_POWER_DOWN]))
		else $error("power down does not follow bit");
	AST_RSVD: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		(run_clock_config & ~run_clk_pkg::RUN_CFG_WMASK)
			== (run_clk_pkg::RUN_CFG_RESET & ~run_clk_pkg::RUN_CFG_WMASK))
		else $error("reserved bits changed");
	AST_USEDIV: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		run_clock_config[run_clk_pkg::POS_USEDIV] |=> o_clk_through_div)
		else $error("divider-use ignored");
	AST_EXT_DIV: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		ext_sel && bypass |=> o_eff_divisor
			== $past(run_clock_config_ext[28:23]))
		else $error("extended divisor not used");
	AST_BYPASS: assert property (@(posedge i_sys_clk) disable iff (i_srst)
		bypass |=> !o_clk_from_pll)
		else $error("bypass did not select oscillator");
endmodule : run_clock_cfg

// ==== dv/testbench.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module testbench;
	logic        clk     = 1'b0;
	logic        srst    = 1'b1;
	logic [3:0]  address = 4'h0;
	logic        rd      = 1'b0;
	logic        wr      = 1'b0;
	logic [31:0] wdata   = 32'h0;
	logic [31:0] gr, gs, gd, readdata, periph_gate, exp_rd;
	logic        waitrequest;
	logic [1:0]  gate_sel;
	logic [1:0]  osc_src;
	logic [31:0] expq[$];
	integer      seed     = 32'h8bf4a2f0;
	int          errors   = 0;
	int          compares = 0;
	int          cycles   = 0;

	run_clock_cfg DUT (
		.i_sys_clk                (clk),
		.i_srst                   (srst),
		.i_address                (address),
		.i_read                   (rd),
		.i_write                  (wr),
		.i_writedata              (wdata),
		.i_byteenable             (4'hf),
		.o_readdata               (readdata),
		.o_waitrequest            (waitrequest),
		.i_min_divisor_limit      (6'h06),
		.i_run_gating_regs        (gr),
		.i_sleep_gating_regs      (gs),
		.i_deep_sleep_gating_regs (gd),
		.o_periph_gate            (periph_gate),
		.o_gate_sel               (gate_sel),
		.o_pll_power_down         (),
		.o_clk_from_pll           (),
		.o_clk_through_div        (),
		.o_eff_divisor            (),
		.o_osc_source             (osc_src),
		.o_crystal_select         ()
	);

	always #2.5 clk = ~clk;

	task automatic wrap_up;
		if (errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up

	// hang guard: whole run needs only about 108 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			wrap_up();
		end
	end

	// read data is taken only at the edge that ends the wait
	always @(posedge clk) begin
		if (rd && !waitrequest) begin
			exp_rd = expq.pop_front();
			`CHK("readdata", exp_rd, readdata)
		end
	end

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		address <= a;
		wdata   <= d;
		wr      <= 1'b1;
		@(posedge clk iff !waitrequest);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		expq.push_back(e);
		address <= a;
		rd      <= 1'b1;
		@(posedge clk iff !waitrequest);
		rd <= 1'b0;
		@(posedge clk);
	endtask : rd_chk

	initial begin
		logic [1:0]  sel;
		logic [31:0] egate;
		gr = $random(seed);
		gs = $random(seed);
		gd = $random(seed);
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd_chk(4'h0, 32'h0780_3ad1);
		rd_chk(4'h4, 32'h0780_2810);
		rd_chk(4'hc, 32'h0000_0f2b);
		rd_chk(4'h2, 32'h0000_0000);
		wr_reg(4'h0, 32'hffff_ffff);
		rd_chk(4'h0, 32'h0fc0_3bf3);
		rd_chk(4'hc, 32'h0000_0faf);
		// bypass off, divisor 2 under limit 6
		wr_reg(4'h0, 32'h0100_02c0);
		rd_chk(4'hc, 32'h0000_06cb);
		wr_reg(4'h0, 32'h0140_0ac0);
		rd_chk(4'hc, 32'h0000_028b);
		wr_reg(4'h4, 32'h9080_2800);
		rd_chk(4'h4, 32'h9080_2800);
		rd_chk(4'hc, 32'h0000_21ab);
		wr_reg(4'h4, 32'h0000_0000);
		for (int a = 0; a < 2; a++) begin
			for (int m = 0; m < 3; m++) begin
				wr_reg(4'h0, 32'h0780_3ad1 | (32'(a) << 27));
				wr_reg(4'h8, 32'(m));
				@(posedge clk);
				@(negedge clk);
				sel   = (a == 1) ? 2'(m) : 2'h0;
				egate = (sel == 2'h1) ? gs : (sel == 2'h2) ? gd : gr;
				`CHK("gate_sel", sel, gate_sel)
				`CHK("periph_gate", egate, periph_gate)
				`CHK("osc_source", 2'h1, osc_src)
			end
		end
		wrap_up();
	end
endmodule : testbench
